//--- rtl/ddc_pkg.sv
// Constants, types and decode helpers for the DRAM command and clock-change tracker
`default_nettype none

package ddc_pkg;
	// ------------------------------------------------------------
	// Commands and states
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		CMD_DESELECT = 4'h0,
		CMD_NOP = 4'h1,
		CMD_ACT = 4'h2,
		CMD_RD = 4'h3,
		CMD_WR = 4'h4,
		CMD_PRE = 4'h5,
		CMD_REF = 4'h6,
		CMD_MODE_SET = 4'h7,
		CMD_RSV = 4'h8
	} ddc_cmd_t;

	typedef enum logic [2:0] {
		ST_INIT = 3'h0,
		ST_IDLE = 3'h1,
		ST_PPD = 3'h2,
		ST_APD = 3'h3
	} ddc_state_t;

	// ------------------------------------------------------------
	// Register map and fields
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_INIT = 8'h08;
	localparam int CTRL_BL8_BIT = 0;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_DLL_BIT = 3;
	localparam int STAT_READY_BIT = 4;
	localparam int STAT_LOST_BIT = 5;
	localparam int STAT_TERM_BIT = 6;
	localparam int STAT_BURST_BIT = 7;
	localparam int STAT_BANKS_LSB = 8;

	// ------------------------------------------------------------
	// Timing and sequence counts
	// ------------------------------------------------------------
	localparam logic [2:0] BURST_HALF_BL4 = 3'h2;
	localparam logic [2:0] BURST_HALF_BL8 = 3'h4;
	localparam int DLL_LOCK_CYCLES = 200;
	localparam logic [3:0] INIT_STEPS = 4'hb;
	localparam int BANKS = 4;

	// Pin pattern to command; select high masks the other strobes
	function automatic ddc_cmd_t ddc_decode(input logic cs_n, input logic ras_n,
		input logic cas_n, input logic we_n);
		logic [2:0] s;
		s = {ras_n, cas_n, we_n};
		if (cs_n) begin
			ddc_decode = CMD_DESELECT;
		end else begin
			case (s)
				3'h7: ddc_decode = CMD_NOP;
				3'h3: ddc_decode = CMD_ACT;
				3'h5: ddc_decode = CMD_RD;
				3'h4: ddc_decode = CMD_WR;
				3'h2: ddc_decode = CMD_PRE;
				3'h1: ddc_decode = CMD_REF;
				3'h0: ddc_decode = CMD_MODE_SET;
				default: ddc_decode = CMD_RSV;
			endcase
		end
	endfunction : ddc_decode

	function automatic logic ddc_idle_cmd(input ddc_cmd_t c);
		ddc_idle_cmd = (c == CMD_NOP) || (c == CMD_DESELECT);
	endfunction : ddc_idle_cmd
endpackage : ddc_pkg

`default_nettype wire

//--- rtl/ddc_cmd_if.sv
// Carrier between the command tracker and the initialisation sequencer
`default_nettype none

interface ddc_cmd_if;
	ddc_pkg::ddc_cmd_t cmd;
	logic [1:0] ba;
	logic a10;
	logic restart;
	logic done;
	logic [3:0] step;
	modport dec (output cmd, output ba, output a10, output restart, input done, input step);
	modport seq (input cmd, input ba, input a10, input restart, output done, output step);
endinterface : ddc_cmd_if

`default_nettype wire

//--- rtl/ddc_init_seq.sv
// Initialisation sequencer: follows the 11 command steps (0 to 10) of the power-up sequence
`default_nettype none

module ddc_init_seq (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	ddc_cmd_if.seq cif
);
	import ddc_pkg::*;

	// ------------------------------------------------------------
	// Expected command per step
	// ------------------------------------------------------------
	// Returns {needs_a10, bank, command}; bank is ignored for precharge and refresh
	function automatic logic [6:0] expect_step(input logic [3:0] idx);
		case (idx)
			4'h0: expect_step = {1'b1, 2'h0, CMD_PRE};
			4'h1: expect_step = {1'b0, 2'h2, CMD_MODE_SET};
			4'h2: expect_step = {1'b0, 2'h3, CMD_MODE_SET};
			4'h3: expect_step = {1'b0, 2'h1, CMD_MODE_SET};
			4'h4: expect_step = {1'b0, 2'h0, CMD_MODE_SET};
			4'h5: expect_step = {1'b1, 2'h0, CMD_PRE};
			4'h6: expect_step = {1'b0, 2'h0, CMD_REF};
			4'h7: expect_step = {1'b0, 2'h0, CMD_REF};
			4'h8: expect_step = {1'b0, 2'h0, CMD_MODE_SET};
			default: expect_step = {1'b0, 2'h1, CMD_MODE_SET};
		endcase
	endfunction : expect_step

	logic [6:0] exp_w;
	logic hit;

	always_comb begin
		exp_w = expect_step(cif.step);
		case (ddc_cmd_t'(exp_w[3:0]))
			CMD_PRE: hit = (cif.cmd == CMD_PRE) && (cif.a10 == exp_w[6]);
			CMD_REF: hit = (cif.cmd == CMD_REF);
			default: hit = (cif.cmd == CMD_MODE_SET) && (cif.ba == exp_w[5:4]);
		endcase
	end

	// ------------------------------------------------------------
	// Step counter
	// ------------------------------------------------------------
	// Out-of-order commands are simply not counted, so a stray refresh never skips a step
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cif.step <= 4'h0;
			cif.done <= 1'b0;
		end else if (cif.restart) begin
			cif.step <= 4'h0;
			cif.done <= 1'b0;
		end else if (!cif.done && hit) begin
			cif.step <= cif.step + 4'h1;
			cif.done <= (cif.step + 4'h1) == INIT_STEPS;
		end
	end

	init_order_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		$rose(cif.done) |-> $past(cif.step) == INIT_STEPS - 4'h1)
		else $error("init finished before the last step");
endmodule : ddc_init_seq

`default_nettype wire

//--- rtl/ddc_tracker.sv
// Device-side command decode, power-down, lock loop and reinitialisation tracker
`default_nettype none

module ddc_tracker #(
	parameter int LOCK_CYCLES = ddc_pkg::DLL_LOCK_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic chip_select_n_i,
	input wire logic row_strobe_n_i,
	input wire logic column_strobe_n_i,
	input wire logic write_enable_n_i,
	input wire logic clock_enable_pin_i,
	input wire logic termination_enable_i,
	input wire logic [1:0] bank_addr_i,
	input wire logic addr10_i,
	input wire logic addr8_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	output logic ready_o,
	output logic power_down_o,
	output logic dll_locked_o,
	output logic data_lost_o
);
	import ddc_pkg::*;

	// ------------------------------------------------------------
	// Pin capture
	// ------------------------------------------------------------
	// Pins come from the controller on this same clock, so one register stage only
	ddc_cmd_t cmd_r;
	logic cke_r;
	logic cke_prev;
	logic term_r;
	logic [1:0] ba_r;
	logic a10_r;
	logic a8_r;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cmd_r <= CMD_DESELECT;
			cke_r <= 1'b0;
			cke_prev <= 1'b0;
			term_r <= 1'b0;
			ba_r <= 2'h0;
			a10_r <= 1'b0;
			a8_r <= 1'b0;
		end else begin
			cmd_r <= ddc_decode(chip_select_n_i, row_strobe_n_i, column_strobe_n_i,
				write_enable_n_i);
			cke_r <= clock_enable_pin_i;
			cke_prev <= cke_r;
			term_r <= termination_enable_i;
			ba_r <= bank_addr_i;
			a10_r <= addr10_i;
			a8_r <= addr8_i;
		end
	end

	// ------------------------------------------------------------
	// Shared decode
	// ------------------------------------------------------------
	ddc_state_t state;
	logic [2:0] burst_cnt;
	logic [BANKS-1:0] banks_open;
	logic [15:0] lock_cnt;
	logic dll_locked;
	logic bl8;
	logic term_err;
	logic cke_fell;
	logic cke_rose;
	logic idle_cmd;
	logic pd_enter;
	logic async_drop;
	logic cmd_live;
	logic dll_reset;
	ddc_cmd_if cif ();

	always_comb begin
		cke_fell = cke_prev && !cke_r;
		cke_rose = !cke_prev && cke_r;
		idle_cmd = ddc_idle_cmd(cmd_r);
		// A drop with a real command or mid-burst is no legal entry
		pd_enter = (state == ST_IDLE) && cke_fell && idle_cmd && (burst_cnt == 3'h0);
		async_drop = (state == ST_IDLE) && cke_fell && !pd_enter;
		cmd_live = ((state == ST_IDLE) || (state == ST_INIT)) && cke_r;
		dll_reset = cmd_live && (cmd_r == CMD_MODE_SET) && a8_r;
	end

	assign cif.cmd = (state == ST_INIT && cke_r) ? cmd_r : CMD_DESELECT;
	assign cif.ba = ba_r;
	assign cif.a10 = a10_r;
	assign cif.restart = async_drop;

	ddc_init_seq u_init (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.cif(cif)
	);

	// ------------------------------------------------------------
	// Device state
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= ST_INIT;
		end else begin
			case (state)
				ST_INIT: begin
					if (cif.done) begin
						state <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (async_drop) begin
						state <= ST_INIT;
					end else if (pd_enter) begin
						state <= (banks_open == '0) ? ST_PPD : ST_APD;
					end
				end
				default: begin
					if (cke_rose && idle_cmd) begin
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Bursts and banks
	// ------------------------------------------------------------
	// A no-op or deselect leaves the counter running to its end
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			burst_cnt <= 3'h0;
		end else if (async_drop) begin
			burst_cnt <= 3'h0;
		end else if (cmd_live && state == ST_IDLE && (cmd_r == CMD_RD || cmd_r == CMD_WR)) begin
			burst_cnt <= bl8 ? BURST_HALF_BL8 : BURST_HALF_BL4;
		end else if (burst_cnt != 3'h0) begin
			burst_cnt <= burst_cnt - 3'h1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			banks_open <= '0;
		end else if (async_drop || state == ST_INIT) begin
			banks_open <= '0;
		end else if (cmd_live && cmd_r == CMD_ACT) begin
			banks_open[ba_r] <= 1'b1;
		end else if (cmd_live && cmd_r == CMD_PRE) begin
			if (a10_r) begin
				banks_open <= '0;
			end else begin
				banks_open[ba_r] <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Lock loop
	// ------------------------------------------------------------
	// Entering precharge power-down stops the loop; only a mode set with A8 high restarts it
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dll_locked <= 1'b0;
			lock_cnt <= 16'h0000;
		end else if (async_drop || (pd_enter && banks_open == '0)) begin
			dll_locked <= 1'b0;
			lock_cnt <= 16'h0000;
		end else if (dll_reset) begin
			dll_locked <= 1'b0;
			lock_cnt <= 16'(LOCK_CYCLES);
		end else if (lock_cnt != 16'h0000) begin
			lock_cnt <= lock_cnt - 16'h0001;
			dll_locked <= (lock_cnt == 16'h0001);
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic wr_ctrl;
	logic wr_status;
	logic [31:0] status_w;

	always_comb begin
		wr_ctrl = reg_wr_i && (reg_addr_i == REG_CTRL);
		wr_status = reg_wr_i && (reg_addr_i == REG_STATUS);
		status_w = '0;
		status_w[STAT_STATE_LSB +: 3] = state;
		status_w[STAT_DLL_BIT] = dll_locked;
		status_w[STAT_READY_BIT] = ready_o;
		status_w[STAT_LOST_BIT] = data_lost_o;
		status_w[STAT_TERM_BIT] = term_err;
		status_w[STAT_BURST_BIT] = (burst_cnt != 3'h0);
		status_w[STAT_BANKS_LSB +: BANKS] = banks_open;
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bl8 <= CTRL_RESET[CTRL_BL8_BIT];
		end else if (wr_ctrl) begin
			bl8 <= reg_wdata_i[CTRL_BL8_BIT];
		end
	end

	// Sticky flags: a new event in the clearing cycle wins
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			data_lost_o <= 1'b0;
			term_err <= 1'b0;
		end else begin
			if (async_drop) begin
				data_lost_o <= 1'b1;
			end else if (wr_status && reg_wdata_i[STAT_LOST_BIT]) begin
				data_lost_o <= 1'b0;
			end
			if (term_r && lock_cnt != 16'h0000) begin
				term_err <= 1'b1;
			end else if (wr_status && reg_wdata_i[STAT_TERM_BIT]) begin
				term_err <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (reg_rd_i) begin
			if (reg_addr_i == REG_CTRL) begin
				reg_rdata_o <= {31'h0000_0000, bl8};
			end else if (reg_addr_i == REG_STATUS) begin
				reg_rdata_o <= status_w;
			end else if (reg_addr_i == REG_INIT) begin
				reg_rdata_o <= {27'h000_0000, cif.done, cif.step};
			end else begin
				reg_rdata_o <= 32'h0000_0000;
			end
		end else begin
			reg_rdata_o <= 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ready_o <= 1'b0;
			power_down_o <= 1'b0;
			dll_locked_o <= 1'b0;
		end else begin
			ready_o <= (state == ST_IDLE) && dll_locked;
			power_down_o <= (state == ST_PPD) || (state == ST_APD);
			dll_locked_o <= dll_locked;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	sequence s_legal_entry;
		state == ST_IDLE && cke_fell && idle_cmd && burst_cnt == 3'h0;
	endsequence

	sequence s_bad_drop;
		state == ST_IDLE && cke_fell && !(idle_cmd && burst_cnt == 3'h0);
	endsequence

	nop_decode_a: assert property (!chip_select_n_i && row_strobe_n_i && column_strobe_n_i
		&& write_enable_n_i |=> cmd_r == CMD_NOP)
		else $error("no-op pattern not decoded");
	deselect_decode_a: assert property (chip_select_n_i |=> cmd_r == CMD_DESELECT)
		else $error("select high not decoded as deselect");
	nop_keeps_burst_a: assert property (burst_cnt > 3'h1 && idle_cmd && !async_drop
		|=> burst_cnt == $past(burst_cnt) - 3'h1)
		else $error("no-op disturbed a running burst");
	pd_entry_a: assert property (s_legal_entry |=> power_down_o == 1'b0
		##0 (state == ST_PPD || state == ST_APD) ##1 power_down_o)
		else $error("power-down not entered");
	ppd_dll_off_a: assert property (s_legal_entry ##0 banks_open == '0
		|=> state == ST_PPD && !dll_locked)
		else $error("precharge power-down kept the lock loop");
	async_loss_a: assert property (s_bad_drop |=> state == ST_INIT && data_lost_o
		##1 !ready_o)
		else $error("unplanned drop not flagged");
	reinit_ready_a: assert property (state == ST_INIT && !cif.done |=> !ready_o)
		else $error("ready before reinitialisation");
	dll_lock_time_a: assert property (dll_reset && !async_drop |=> !dll_locked
		##LOCK_CYCLES dll_locked)
		else $error("lock time not honoured");
endmodule : ddc_tracker

`default_nettype wire

//--- tb/ddc_ctl_model.sv
// Controller-side model driving the DRAM command, enable and termination pins
`default_nettype none

module ddc_ctl_model (
	input wire logic clk_i,
	output logic cs_n_o,
	output logic ras_n_o,
	output logic cas_n_o,
	output logic we_n_o,
	output logic cke_o,
	output logic term_o,
	output logic [1:0] ba_o,
	output logic a10_o,
	output logic a8_o,
	output logic slow_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// Init steps as {strobes, bank, lock-loop reset}
	// ------------------------------------------------------------
	localparam logic [5:0] INIT_SEQ [11] = '{6'h10, 6'h04, 6'h06, 6'h02, 6'h01, 6'h10,
		6'h08, 6'h08, 6'h00, 6'h02, 6'h02};

	initial begin
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'h7;
		{cke_o, term_o, ba_o, a10_o, a8_o, slow_o} = 7'h00;
	end

	task automatic issue(input logic [2:0] s, input logic [1:0] ba, input logic a8);
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		{ras_n_o, cas_n_o, we_n_o} <= s;
		ba_o <= ba;
		// Precharge always closes every bank
		a10_o <= (s == 3'h2);
		a8_o <= a8;
		@(posedge clk_i);
		{ras_n_o, cas_n_o, we_n_o} <= 3'h7;
		a10_o <= 1'b0;
		a8_o <= 1'b0;
	endtask : issue

	task automatic init_seq();
		@(posedge clk_i);
		cke_o <= 1'b1;
		for (int i = 0; i < 11; i++) begin
			issue(INIT_SEQ[i][5:3], INIT_SEQ[i][2:1], INIT_SEQ[i][0]);
		end
	endtask : init_seq

	task automatic deselect(input int n);
		repeat (n) begin
			@(posedge clk_i);
			cs_n_o <= 1'b1;
			// Unselected strobes wander so a stale level cannot pass for a command
			{ras_n_o, cas_n_o, we_n_o} <= 3'($urandom());
		end
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		{ras_n_o, cas_n_o, we_n_o} <= 3'h7;
	endtask : deselect

	task automatic set_cke(input logic v);
		@(posedge clk_i);
		cke_o <= v;
	endtask : set_cke

	task automatic set_term(input logic v);
		@(posedge clk_i);
		term_o <= v;
	endtask : set_term

	// Only called in precharge power-down with enable and termination held low
	task automatic clk_switch();
		repeat (2) @(posedge clk_i);
		slow_o <= 1'b1;
		repeat (4) @(posedge clk_i);
	endtask : clk_switch
endmodule : ddc_ctl_model

`default_nettype wire

//--- tb/ddc_tracker_tb.sv
// Self-checking bench for the DRAM command and clock-change tracker
`default_nettype none

module ddc_tracker_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import ddc_pkg::*;

	localparam int LOCK = 8;
	logic clk_sys_i, resetn_i, cs_n, ras_n, cas_n, we_n, cke, term, a10, a8, slow;
	logic [1:0] ba, rb;
	logic [7:0] reg_addr, ua;
	logic [31:0] reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, ready, pd, dll, lost;
	int fails = 0;
	int compares = 0;
	// Reference model of the device state
	int m_state = 0, m_banks = 0, m_lock = 0, m_lost = 0, m_term = 0;

	initial begin
		clk_sys_i = 1'b0;
		forever begin
			#((slow === 1'b1) ? 22 : 20);
			clk_sys_i = ~clk_sys_i;
		end
	end

	ddc_tracker #(.LOCK_CYCLES(LOCK)) dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.chip_select_n_i(cs_n), .row_strobe_n_i(ras_n), .column_strobe_n_i(cas_n),
		.write_enable_n_i(we_n), .clock_enable_pin_i(cke), .termination_enable_i(term),
		.bank_addr_i(ba), .addr10_i(a10), .addr8_i(a8), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
		.ready_o(ready), .power_down_o(pd), .dll_locked_o(dll), .data_lost_o(lost));

	ddc_ctl_model u_ctl (.clk_i(clk_sys_i), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n),
		.we_n_o(we_n), .cke_o(cke), .term_o(term), .ba_o(ba), .a10_o(a10), .a8_o(a8),
		.slow_o(slow));

	// ------------------------------------------------------------
	// Checking and bus tasks
	// ------------------------------------------------------------
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, exp, seen);
		end
	endtask : check

	function automatic logic m_rdy();
		return (m_state == 1) && (m_lock == 1);
	endfunction : m_rdy

	function automatic logic [31:0] stat_exp();
		return {20'h0, 4'(m_banks), 1'b0, 1'(m_term), 1'(m_lost), m_rdy(), 1'(m_lock),
			3'(m_state)};
	endfunction : stat_exp

	task automatic outs(input string n, input logic p);
		check(n, {28'h0, ready, pd, dll, lost}, {28'h0, m_rdy(), p, 1'(m_lock), 1'(m_lost)});
	endtask : outs

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys_i);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		@(posedge clk_sys_i);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys_i);
		reg_rd <= 1'b0;
		#1 check(n, reg_rdata & m, e & m);
	endtask : rd

	task automatic give_verdict();
		if (fails == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : give_verdict

	initial begin
		#100000;
		fails++;
		give_verdict();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		void'($urandom(64183));
		resetn_i = 1'b0;
		{reg_addr, reg_wdata, reg_wr, reg_rd} = 42'h0;
		repeat (5) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		@(posedge clk_sys_i);
		#1 outs("reset outputs", 1'b0);
		rd("ctrl reset", REG_CTRL, '1, CTRL_RESET);
		rd("status reset", REG_STATUS, '1, stat_exp());
		ua = 8'(($urandom() % 61) * 4 + 12);
		wr(ua, $urandom());
		rd("unmapped", ua, '1, 32'h0);
		u_ctl.init_seq();
		m_state = 1;
		m_lock = 1;
		repeat (LOCK + 4) @(posedge clk_sys_i);
		#1 outs("after init", 1'b0);
		rd("init done", REG_INIT, 32'h1f, {27'h0, 1'b1, INIT_STEPS});
		u_ctl.deselect(24);
		rd("after deselect", REG_STATUS, 32'hfff, stat_exp());
		// Read burst kept alive by the no-ops that follow it
		wr(REG_CTRL, $urandom() | 32'h1);
		rb = 2'($urandom());
		u_ctl.issue(3'h3, rb, 1'b0);
		m_banks = 1 << rb;
		u_ctl.issue(3'h5, rb, 1'b0);
		@(posedge clk_sys_i);
		rd("burst running", REG_STATUS, 32'h80, 32'h80);
		repeat (6) @(posedge clk_sys_i);
		rd("burst over", REG_STATUS, 32'hfff, stat_exp());
		// Rate change through precharge power-down
		u_ctl.issue(3'h2, 2'h0, 1'b0);
		m_banks = 0;
		u_ctl.set_cke(1'b0);
		m_state = 2;
		m_lock = 0;
		repeat (4) @(posedge clk_sys_i);
		#1 outs("precharge power-down", 1'b1);
		rd("status ppd", REG_STATUS, 32'hfff, stat_exp());
		u_ctl.clk_switch();
		u_ctl.set_cke(1'b1);
		m_state = 1;
		repeat (4) @(posedge clk_sys_i);
		#1 outs("pd exit", 1'b0);
		u_ctl.issue(3'h0, 2'h1, 1'b1);
		// Termination raised during relock on purpose
		u_ctl.set_term(1'b1);
		u_ctl.set_term(1'b0);
		u_ctl.issue(3'h0, 2'h0, 1'b0);
		m_lock = 1;
		m_term = 1;
		repeat (LOCK + 4) @(posedge clk_sys_i);
		rd("relock", REG_STATUS, 32'hfff, stat_exp());
		wr(REG_STATUS, $urandom() | 32'h40);
		m_term = 0;
		rd("term clear", REG_STATUS, 32'hfff, stat_exp());
		// Power-down with a row open
		rb = 2'($urandom());
		u_ctl.issue(3'h3, rb, 1'b0);
		m_banks = 1 << rb;
		u_ctl.set_cke(1'b0);
		m_state = 3;
		repeat (4) @(posedge clk_sys_i);
		#1 outs("active power-down", 1'b1);
		rd("state apd", REG_STATUS, 32'hfff, stat_exp());
		u_ctl.set_cke(1'b1);
		m_state = 1;
		repeat (4) @(posedge clk_sys_i);
		#1 outs("apd exit", 1'b0);
		// Enable dropped in mid write burst, short bursts this time
		wr(REG_CTRL, $urandom() & 32'hffff_fffe);
		u_ctl.issue(3'h4, rb, 1'b0);
		u_ctl.set_cke(1'b0);
		m_state = 0;
		m_lost = 1;
		m_lock = 0;
		m_banks = 0;
		// Clocks keep running well past the drop, so the drop delay is always met
		repeat (4) @(posedge clk_sys_i);
		#1 check("lost flag", {31'h0, lost}, 32'h1);
		rd("status lost", REG_STATUS, 32'hfff, stat_exp());
		wr(REG_STATUS, $urandom() | 32'h20);
		m_lost = 0;
		rd("lost clear", REG_STATUS, 32'h20, 32'h0);
		u_ctl.init_seq();
		m_state = 1;
		m_lock = 1;
		repeat (LOCK + 4) @(posedge clk_sys_i);
		#1 outs("reinit", 1'b0);
		rd("status reinit", REG_STATUS, 32'hfff, stat_exp());
		give_verdict();
	end
endmodule : ddc_tracker_tb

`default_nettype wire
